/* File: hw/flash_data_write_control.sv */
// Flash data memory write sequencer with control register and array model
//
// Function
// - Reads return array data; writes start a long programming sequence.
// - Internal execution: CPU held idle until the write completes.
// - External execution: CPU runs on; busy flag reports progress.
// - Writes accepted only with write enable and data enable both set.
// - Programming only clears bits: new value is old AND data.
// - Erase sets every byte of the addressed page to FF.
// - Two pages of 128 bytes; many bytes programmed per operation.
// - Load buffer holds 64 bytes, one half page.
// - With page load set, writes only fill the buffer.
// - Clear page load, final write commits half page at its address.
// - Write with page load clear and empty buffer programs one byte.
// - Buffer tracking cleared at the end of every write; stored bytes remain.
// - Auto-erase erases whole page first, then programs addressed half.
// - No write sequence begins while brown-out is signalled.
// - Brown-out during a write sets the error flag.
// - Control register at 96H; upper five bits reset to zero.
// - Array sits at 0000H-00FFH, reached by 16-bit pointer moves only.
// - In-application enable, with the in-application fuse set, redirects pointer moves away from the array.
// - Error flag set by hardware, cleared only by software write.
// - Write-block bit low below programming voltage, high above it.
`timescale 1ns/1ps
module flash_data_write_control
  import flash_data_space_pkg::*;
#(
  parameter int ERASE_CNT = ERASE_CYCLES,
  parameter int PROG_CNT = PROG_CYCLES,
  parameter int SIZE = 2 * PAGE_BYTES
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic xmov_wr_in,
  input wire logic xmov_rd_in,
  input wire logic xmov_ptr16_in,
  input wire logic [15:0] xmov_addr_in,
  input wire logic [7:0] xmov_wdata_in,
  output logic [7:0] xmov_rdata_out,
  output logic xmov_hit_out,
  input wire logic in_app_fuse_in,
  input wire logic exec_external_in,
  input wire logic brownout_in,
  input wire logic vdd_ok_in,
  output logic cpu_stall_out,
  output logic irq_defer_out
);
  flash_data_space_buf_if bif();
  flash_data_space_load_buffer #(.DEPTH(HALF_BYTES)) u_buf (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .bus(bif)
  );

  logic [7:0] array_q [SIZE];
  logic [4:0] ctl_q;
  logic err_q;
  logic [2:0] bo_sync_q;
  logic [2:0] vdd_sync_q;
  logic bo_q;
  logic vdd_q;
  seq_state_t state_q;
  logic [31:0] cnt_q;
  logic [6:0] idx_q;
  logic tgt_page_q;
  logic tgt_half_q;
  logic single_q;
  logic [5:0] single_idx_q;
  logic [7:0] single_data_q;
  logic busy;
  logic flash_data_space_sel;
  logic wr_ok;
  logic start;
  logic ctl_wr;

  // Pin inputs pass three flops; a change counts when the last two agree
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      bo_sync_q <= 3'h0;
      vdd_sync_q <= 3'h0;
      bo_q <= 1'b0;
      vdd_q <= 1'b0;
    end else begin
      bo_sync_q <= {bo_sync_q[1:0], brownout_in};
      vdd_sync_q <= {vdd_sync_q[1:0], vdd_ok_in};
      if (bo_sync_q[2] == bo_sync_q[1]) begin
        bo_q <= bo_sync_q[2];
      end
      if (vdd_sync_q[2] == vdd_sync_q[1]) begin
        vdd_q <= vdd_sync_q[2];
      end
    end
  end

  assign busy = (state_q != ST_IDLE);
  assign ctl_wr = sfr_wr_in && (sfr_addr_in == NVMC_ADDR);
  // Array only for 16-bit pointer moves, data enable set, in-app mode off
  assign flash_data_space_sel = xmov_ptr16_in && ctl_q[BIT_DATA_ENABLE - 3] && (xmov_addr_in <= FLASH_DATA_LAST)
                     && !(ctl_q[BIT_IN_APP - 3] && in_app_fuse_in);
  assign xmov_hit_out = flash_data_space_sel && (xmov_rd_in || xmov_wr_in);
  // A write move during busy is ignored; the array cannot take a new one mid-sequence
  assign wr_ok = xmov_wr_in && flash_data_space_sel && ctl_q[BIT_WR_ENABLE - 3] && !busy;
  assign start = wr_ok && !ctl_q[BIT_PAGE_LOAD - 3] && !bo_q;

  // ctl_q holds bits 7..3: in-app, auto-erase, page load, write enable, data enable
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ctl_q <= NVMC_RESET[7:3];
    end else if (ctl_wr) begin
      ctl_q <= sfr_wdata_in[7:3];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      err_q <= NVMC_RESET[BIT_ERR];
    end else if (busy && bo_q) begin
      err_q <= 1'b1;
    end else if (ctl_wr) begin
      err_q <= sfr_wdata_in[BIT_ERR];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in && sfr_addr_in == NVMC_ADDR) begin
      sfr_rdata_out <= {ctl_q, err_q, busy, vdd_q};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      xmov_rdata_out <= 8'h00;
    end else if (xmov_rd_in && flash_data_space_sel) begin
      xmov_rdata_out <= array_q[xmov_addr_in[7:0]];
    end
  end

  // Idle-while-write for internal code; external code polls busy
  assign cpu_stall_out = busy && !exec_external_in;
  assign irq_defer_out = busy;

  // Buffer fill: page load set deposits; the final commit byte is also buffered
  assign bif.wr = wr_ok && (ctl_q[BIT_PAGE_LOAD - 3] || (start && bif.any));
  assign bif.wr_idx = xmov_addr_in[5:0];
  assign bif.wr_data = xmov_wdata_in;
  assign bif.rd_idx = idx_q[5:0];
  assign bif.clr = busy && (state_q == ST_PROG) && (cnt_q == 32'd0) && (idx_q[6] || single_q);

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 32'd0;
      idx_q <= 7'h00;
      tgt_page_q <= 1'b0;
      tgt_half_q <= 1'b0;
      single_q <= 1'b0;
      single_idx_q <= 6'h00;
      single_data_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            tgt_page_q <= xmov_addr_in[7];
            tgt_half_q <= xmov_addr_in[6];
            single_q <= !bif.any;
            single_idx_q <= xmov_addr_in[5:0];
            single_data_q <= xmov_wdata_in;
            idx_q <= 7'h00;
            if (ctl_q[BIT_AUTO_ERASE - 3]) begin
              state_q <= ST_ERASE;
              cnt_q <= 32'(ERASE_CNT - 1);
            end else begin
              state_q <= ST_PROG;
              cnt_q <= 32'(PROG_CNT - 1);
            end
          end
        end
        ST_ERASE: begin
          if (cnt_q != 32'd0) begin
            cnt_q <= cnt_q - 32'd1;
          end else begin
            state_q <= ST_PROG;
            cnt_q <= 32'(PROG_CNT - 1);
          end
        end
        ST_PROG: begin
          if (cnt_q != 32'd0) begin
            cnt_q <= cnt_q - 32'd1;
          end else if (single_q || idx_q[6]) begin
            state_q <= ST_IDLE;
          end else begin
            idx_q <= idx_q + 7'h01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Array model: erase whole page at end of erase; program walks the half page, or writes one byte for a single write
  always_ff @(posedge sys_clk_in) begin
    if (state_q == ST_ERASE && cnt_q == 32'd0 && !bo_q) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        array_q[{tgt_page_q, 7'(i)}] <= ERASED_BYTE;
      end
    end else if (state_q == ST_PROG && cnt_q == 32'd0 && !bo_q) begin
      if (single_q) begin
        array_q[{tgt_page_q, tgt_half_q, single_idx_q}] <=
          array_q[{tgt_page_q, tgt_half_q, single_idx_q}] & single_data_q;
      end else if (!idx_q[6] && bif.rd_valid) begin
        array_q[{tgt_page_q, tgt_half_q, idx_q[5:0]}] <=
          array_q[{tgt_page_q, tgt_half_q, idx_q[5:0]}] & bif.rd_data;
      end
    end
  end
endmodule

/* File: hw/flash_data_space_pkg.sv */
// Constants and types for the flash data write sequencer
package flash_data_space_pkg;
  localparam logic [7:0] NVMC_ADDR = 8'h96;
  localparam logic [7:0] NVMC_RESET = 8'h00;
  localparam int BIT_IN_APP = 7;
  localparam int BIT_AUTO_ERASE = 6;
  localparam int BIT_PAGE_LOAD = 5;
  localparam int BIT_WR_ENABLE = 4;
  localparam int BIT_DATA_ENABLE = 3;
  localparam int BIT_ERR = 2;
  localparam int BIT_BUSY = 1;
  localparam int BIT_WINH = 0;
  localparam logic [15:0] FLASH_DATA_LAST = 16'h00FF;
  localparam int PAGE_BYTES = 128;
  localparam int HALF_BYTES = 64;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam int CLK_MHZ = 200;
  localparam int ERASE_TIME_US = 2000;
  localparam int PROG_TIME_US = 2000;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} seq_state_t;
endpackage

/* File: hw/flash_data_space_buf_if.sv */
// Signals between the sequencer and its load buffer
`timescale 1ns/1ps
interface flash_data_space_buf_if;
  logic wr;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic clr;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_valid;
  logic any;
  modport ctrl (output wr, output wr_idx, output wr_data, output clr, output rd_idx,
                input rd_data, input rd_valid, input any);
  modport buffer (input wr, input wr_idx, input wr_data, input clr, input rd_idx,
                  output rd_data, output rd_valid, output any);
endinterface

/* File: hw/flash_data_space_load_buffer.sv */
// Half-page load buffer with per-byte loaded tracking
`timescale 1ns/1ps
module flash_data_space_load_buffer #(
  parameter int DEPTH = 64
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  flash_data_space_buf_if.buffer bus
);
  logic [7:0] mem_q [DEPTH];
  logic [DEPTH-1:0] loaded_q;
  // First load of a location wins; a reload is dropped, like the real array
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || bus.clr) begin
      loaded_q <= '0;
    end else if (bus.wr && !loaded_q[bus.wr_idx]) begin
      loaded_q[bus.wr_idx] <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (bus.wr && !loaded_q[bus.wr_idx]) begin
      mem_q[bus.wr_idx] <= bus.wr_data;
    end
  end
  assign bus.rd_data = mem_q[bus.rd_idx];
  assign bus.rd_valid = loaded_q[bus.rd_idx];
  assign bus.any = |loaded_q;
endmodule

/* File: tb/flash_data_space_asserts.sv */
// Port checker for the flash data write sequencer
`timescale 1ns/1ps
module flash_data_space_asserts #(
  parameter int ERASE_CNT = 4,
  parameter int PROG_CNT = 4
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic xmov_wr_in,
  input wire logic xmov_rd_in,
  input wire logic xmov_ptr16_in,
  input wire logic [15:0] xmov_addr_in,
  input wire logic [7:0] xmov_rdata_out,
  input wire logic xmov_hit_out,
  input wire logic exec_external_in,
  input wire logic brownout_in,
  input wire logic cpu_stall_out,
  input wire logic irq_defer_out
);
  // Longest sequence is an erase plus a full half page
  localparam int MAXB = ERASE_CNT + 65 * PROG_CNT + 80;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_brown_held;
    brownout_in [*5];
  endsequence
  sequence s_busy_run;
    irq_defer_out [*3];
  endsequence
  a_stall_tracks: assert property (cpu_stall_out == (irq_defer_out && !exec_external_in))
    else $error("stall does not follow busy");
  a_start_cause: assert property ($rose(irq_defer_out) |-> $past(xmov_wr_in && xmov_hit_out))
    else $error("busy rose without a write move");
  a_busy_min: assert property ($rose(irq_defer_out) |-> s_busy_run)
    else $error("busy dropped too early");
  a_busy_end: assert property ($rose(irq_defer_out) |-> ##[1:MAXB] !irq_defer_out)
    else $error("busy never ended");
  a_hit_range: assert property (xmov_hit_out |-> xmov_ptr16_in && xmov_addr_in <= 16'h00FF)
    else $error("array hit outside its window");
  a_reg_hold: assert property (!$past(sfr_rd_in) |-> $stable(sfr_rdata_out))
    else $error("register data moved without a read");
  a_read_hold: assert property (!$past(xmov_rd_in && xmov_hit_out) |-> $stable(xmov_rdata_out))
    else $error("array data moved without a read");
  a_brown_block: assert property (s_brown_held ##0 !irq_defer_out |=> !irq_defer_out)
    else $error("write began during brown-out");
endmodule
bind flash_data_write_control flash_data_space_asserts #(.ERASE_CNT(ERASE_CNT), .PROG_CNT(PROG_CNT)) u_flash_data_space_asserts (
  .sys_clk_in, .rstn_in, .sfr_rd_in, .sfr_rdata_out, .xmov_wr_in, .xmov_rd_in, .xmov_ptr16_in,
  .xmov_addr_in, .xmov_rdata_out, .xmov_hit_out, .exec_external_in, .brownout_in, .cpu_stall_out, .irq_defer_out);

/* File: tb/cpu_move_model.sv */
// CPU core model issuing register accesses and external data moves
`timescale 1ns/1ps
module cpu_move_model (
  input wire logic sys_clk_in,
  input wire logic cpu_stall_in,
  input wire logic xmov_hit_in,
  output logic sfr_wr_out = 1'h0,
  output logic sfr_rd_out = 1'h0,
  output logic [7:0] sfr_addr_out = 8'h00,
  output logic [7:0] sfr_wdata_out = 8'h00,
  output logic xmov_wr_out = 1'h0,
  output logic xmov_rd_out = 1'h0,
  output logic xmov_ptr16_out = 1'h0,
  output logic [15:0] xmov_addr_out = 16'h0000,
  output logic [7:0] xmov_wdata_out = 8'h00
);
  logic last_hit = 1'h0;
  // An idle core issues nothing while stalled; on release strobes drop, address and data invert
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    while (cpu_stall_in === 1'h1) @(negedge sys_clk_in);
    sfr_wr_out = w;
    sfr_rd_out = !w;
    sfr_addr_out = a;
    sfr_wdata_out = d;
    @(negedge sys_clk_in);
    {sfr_wr_out, sfr_rd_out, sfr_addr_out, sfr_wdata_out} = {2'h0, ~a, ~d};
    @(negedge sys_clk_in);
  endtask
  task automatic mv(input logic w, input logic p, input logic [15:0] a, input logic [7:0] d);
    while (cpu_stall_in === 1'h1) @(negedge sys_clk_in);
    xmov_wr_out = w;
    xmov_rd_out = !w;
    xmov_ptr16_out = p;
    xmov_addr_out = a;
    xmov_wdata_out = d;
    @(negedge sys_clk_in);
    last_hit = xmov_hit_in;
    {xmov_wr_out, xmov_rd_out, xmov_addr_out, xmov_wdata_out} = {2'h0, ~a, ~d};
    @(negedge sys_clk_in);
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the flash data write sequencer
`timescale 1ns/1ps
module testbench;
  import flash_data_space_pkg::*;
  logic sys_clk_in = 0, rstn_in = 0, in_app_fuse_in = 1, exec_external_in = 0, brownout_in = 0, vdd_ok_in = 1;
  logic sfr_wr_in, sfr_rd_in, xmov_wr_in, xmov_rd_in, xmov_ptr16_in, xmov_hit_out, cpu_stall_out, irq_defer_out;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, xmov_wdata_in, xmov_rdata_out, d;
  logic [15:0] xmov_addr_in;
  logic [7:0] m [256];
  logic [7:0] q [$];
  int error_cnt = 0, checks_done = 0, seed = 89, cyc = 0, i;
  flash_data_write_control #(.ERASE_CNT(4), .PROG_CNT(12)) u_flash_data_write_control (.sys_clk_in, .rstn_in,
    .sfr_wr_in, .sfr_rd_in, .sfr_addr_in, .sfr_wdata_in, .sfr_rdata_out, .xmov_wr_in, .xmov_rd_in,
    .xmov_ptr16_in, .xmov_addr_in, .xmov_wdata_in, .xmov_rdata_out, .xmov_hit_out, .in_app_fuse_in,
    .exec_external_in, .brownout_in, .vdd_ok_in, .cpu_stall_out, .irq_defer_out);
  cpu_move_model u_cpu_move_model (.sys_clk_in, .cpu_stall_in(cpu_stall_out), .xmov_hit_in(xmov_hit_out),
    .sfr_wr_out(sfr_wr_in), .sfr_rd_out(sfr_rd_in), .sfr_addr_out(sfr_addr_in), .sfr_wdata_out(sfr_wdata_in),
    .xmov_wr_out(xmov_wr_in), .xmov_rd_out(xmov_rd_in), .xmov_ptr16_out(xmov_ptr16_in),
    .xmov_addr_out(xmov_addr_in), .xmov_wdata_out(xmov_wdata_in));
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task cmp(input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task cf(input logic e, input logic g);
    cmp({7'h00, e}, {7'h00, g});
  endtask
  task rc(input logic [7:0] e);
    u_cpu_move_model.sfr(1'h0, NVMC_ADDR, 8'h00);
    cmp(e, sfr_rdata_out);
  endtask
  task cw(input logic [7:0] v);
    u_cpu_move_model.sfr(1'h1, NVMC_ADDR, v);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    u_cpu_move_model.mv(1'h1, 1'h1, {8'h00, a}, v);
  endtask
  task ht(input logic w, input logic p, input logic [15:0] a, input logic e);
    u_cpu_move_model.mv(w, p, a, 8'h00);
    cf(e, u_cpu_move_model.last_hit);
  endtask
  // Polls busy the way externally running code must
  task wd();
    int n;
    n = 0;
    do begin
      u_cpu_move_model.sfr(1'h0, NVMC_ADDR, 8'h00);
      n++;
    end while (sfr_rdata_out[BIT_BUSY] !== 1'h0 && n < 300);
  endtask
  task rb();
    for (i = 0; i < 256; i++) begin
      u_cpu_move_model.mv(1'h0, 1'h1, i[15:0], 8'h00);
      cmp(m[i], xmov_rdata_out);
    end
    $display("test readback done");
  endtask
  initial begin
    repeat (16) @(negedge sys_clk_in);
    rstn_in = 1'h1;
    repeat (4) @(negedge sys_clk_in);
    rc(8'h01);
    u_cpu_move_model.sfr(1'h1, 8'h95, 8'hFF);
    cw(8'h03);
    rc(8'h01);
    for (int p = 0; p < 2; p++) begin
      cw(8'h58);
      wr({p[0], 7'h00}, 8'hFF);
      cf(1'h1, cpu_stall_out);
      wd();
      for (i = 0; i < 128; i++) m[p * 128 + i] = ERASED_BYTE;
    end
    rb();
    cw(8'h18);
    repeat (6) begin
      i = $random(seed) & 8'hFF;
      d = $random(seed);
      wr(i[7:0], d);
      wd();
      m[i] = m[i] & d;
    end
    cw(8'h38);
    for (int k = 0; k < 16; k++) begin
      d = $random(seed);
      wr(8'hC0 + 8'(2 * k), d);
      q.push_back(d);
    end
    cf(1'h0, cpu_stall_out);
    cw(8'h18);
    d = $random(seed);
    wr(8'hFF, d);
    wd();
    foreach (q[k]) m[8'hC0 + 2 * k] = m[8'hC0 + 2 * k] & q[k];
    m[8'hFF] = m[8'hFF] & d;
    wr(8'h41, 8'h00);
    wd();
    m[8'h41] = 8'h00;
    cw(8'h08);
    wr(8'h10, 8'h00);
    cf(1'h0, cpu_stall_out);
    cw(8'h10);
    ht(1'h1, 1'h1, 16'h0011, 1'h0);
    cw(8'h98);
    ht(1'h0, 1'h1, 16'h0005, 1'h0);
    in_app_fuse_in = 1'h0;
    ht(1'h0, 1'h1, 16'h0005, 1'h1);
    cw(8'h18);
    ht(1'h0, 1'h0, 16'h0005, 1'h0);
    ht(1'h0, 1'h1, 16'h0100, 1'h0);
    ht(1'h0, 1'h1, 16'h00FF, 1'h1);
    $display("test access done");
    exec_external_in = 1'h1;
    d = $random(seed);
    wr(8'h20, d);
    cf(1'h0, cpu_stall_out);
    rc(8'h1B);
    wd();
    m[8'h20] = m[8'h20] & d;
    exec_external_in = 1'h0;
    brownout_in = 1'h1;
    repeat (6) @(negedge sys_clk_in);
    wr(8'h30, 8'h00);
    rc(8'h19);
    brownout_in = 1'h0;
    repeat (6) @(negedge sys_clk_in);
    wr(8'h31, 8'h00);
    brownout_in = 1'h1;
    wd();
    rc(8'h1D);
    brownout_in = 1'h0;
    repeat (6) @(negedge sys_clk_in);
    cw(8'h18);
    rc(8'h19);
    vdd_ok_in = 1'h0;
    repeat (6) @(negedge sys_clk_in);
    rc(8'h18);
    vdd_ok_in = 1'h1;
    $display("test status done");
    rb();
    final_report();
  end
endmodule
